/* File: system_tick_pkg.sv */
package system_tick_pkg;

  // ==========================================================
  // widths
  localparam int CNT_W  = 24;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 16;

  // ==========================================================
  // register offsets above the private peripheral base
  localparam logic [ADDR_W-1:0] OFS_TICK_CONTROL_STATUS = 16'hE010;
  localparam logic [ADDR_W-1:0] OFS_TICK_RELOAD_VALUE   = 16'hE014;
  localparam logic [ADDR_W-1:0] OFS_TICK_CURRENT_VALUE  = 16'hE018;
  localparam logic [ADDR_W-1:0] OFS_TICK_CALIBRATION    = 16'hE01C;

  // ==========================================================
  // field positions
  localparam int BIT_COUNTER_ENABLE        = 0;
  localparam int BIT_WRAP_INTERRUPT_ENABLE = 1;
  localparam int BIT_CLOCK_SOURCE_SELECT   = 2;
  localparam int BIT_WRAP_FLAG             = 16;
  localparam int BIT_CALIB_SKEW            = 30;
  localparam int BIT_NO_REFERENCE_CLOCK    = 31;

  // ==========================================================
  // reset and fixed values
  localparam logic              CTRL_RESET = 1'b0;
  localparam logic [CNT_W-1:0]  COUNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0]  COUNT_ONE  = 24'h000001;
  localparam logic [DATA_W-1:0] WORD_ZERO  = 32'h00000000;

endpackage

/* File: system_tick_timer.sv */
`timescale 1ns/1ps
// How it works
// - wrap flag reads 1 after reaching zero
// - reading control/status clears the wrap flag
// - bit 2 picks reference or processor clock
// - no reference clock forces source bit one
// - interrupt enable gates the tick exception request
// - enable bit gates all counting
// - reload value loads on the tick after the counter reaches zero
// - events only on one-to-zero step
// - period equals reload plus one ticks
// - reload and current reset to zero until programmed
// - current reads live; any write clears
// - current write also clears wrap flag
// - calibration bit 31 reports no reference
// - calibration bit 30 reports inexact count
// - calibration low bits give ten-ms count
// - registers at 0xE010 through 0xE01C
// - reference is one-microsecond count enable pulse
module system_tick_timer #(
  parameter logic                              NO_REFERENCE_CLOCK    = 1'b0,
  parameter logic                              CALIB_SKEW            = 1'b0,
  parameter logic [system_tick_pkg::CNT_W-1:0] TEN_MILLISECOND_COUNT = 24'h000000
) (
  // clock and reset
  input  wire logic                                i_clk_sys,
  input  wire logic                                i_rst,
  // register port, word accesses only
  input  wire logic                                i_reg_read,
  input  wire logic                                i_reg_write,
  input  wire logic [system_tick_pkg::ADDR_W-1:0]  i_reg_addr,
  input  wire logic [system_tick_pkg::DATA_W-1:0]  i_reg_wdata,
  output logic      [system_tick_pkg::DATA_W-1:0]  o_reg_rdata,
  output logic                                     o_reg_ack,
  // one microsecond reference pulse from the watchdog
  input  wire logic                                i_reference_tick,
  // exception request to the interrupt controller
  output logic                                     o_tick_exception_request
);
  import system_tick_pkg::*;

  // ==========================================================
  // state
  logic             counter_enable;
  logic             wrap_interrupt_enable;
  logic             clock_source_select;
  logic             wrap_flag;
  logic [CNT_W-1:0] reload_value;
  logic             ref_pulse;

  logic             next_counter_enable;
  logic             next_wrap_interrupt_enable;
  logic             next_clock_source_select;
  logic             next_wrap_flag;
  logic [CNT_W-1:0] next_reload_value;
  logic [DATA_W-1:0] next_rdata;
  logic             next_ack;
  logic             next_exception;

  logic             source_effective;
  logic             wr_csr, rd_csr, wr_rvr, wr_cvr;

  tick_count_if cnt_if ();

  // ==========================================================
  // submodules
  tick_ref_sync u_ref_sync (
    .i_clk_sys        (i_clk_sys),
    .i_rst            (i_rst),
    .i_reference_tick (i_reference_tick),
    .o_ref_pulse      (ref_pulse)
  );

  tick_down_counter u_counter (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .cnt       (cnt_if.core)
  );

  // ==========================================================
  // address decode, a write wins if both strobes come together
  always_comb begin
    wr_csr = i_reg_write && (i_reg_addr == OFS_TICK_CONTROL_STATUS);
    wr_rvr = i_reg_write && (i_reg_addr == OFS_TICK_RELOAD_VALUE);
    wr_cvr = i_reg_write && (i_reg_addr == OFS_TICK_CURRENT_VALUE);
    rd_csr = i_reg_read && !i_reg_write && (i_reg_addr == OFS_TICK_CONTROL_STATUS);
  end

  // ==========================================================
  // clock source and count enable
  always_comb begin
    source_effective = clock_source_select | NO_REFERENCE_CLOCK;
    // reference is a count enable, not a clock of its own
    cnt_if.tick   = counter_enable & (source_effective | ref_pulse);
    cnt_if.clear  = wr_cvr;
    cnt_if.reload = reload_value;
  end

  // ==========================================================
  // control and flag registers
  always_comb begin
    next_counter_enable        = counter_enable;
    next_wrap_interrupt_enable = wrap_interrupt_enable;
    next_clock_source_select   = clock_source_select;
    next_reload_value          = reload_value;
    next_wrap_flag             = wrap_flag;
    if (wr_csr) begin
      next_counter_enable        = i_reg_wdata[BIT_COUNTER_ENABLE];
      next_wrap_interrupt_enable = i_reg_wdata[BIT_WRAP_INTERRUPT_ENABLE];
      next_clock_source_select   = i_reg_wdata[BIT_CLOCK_SOURCE_SELECT];
    end
    if (wr_rvr) begin
      next_reload_value = i_reg_wdata[CNT_W-1:0];
    end
    if (rd_csr) begin
      next_wrap_flag = CTRL_RESET;
    end
    if (wr_cvr) begin
      next_wrap_flag = CTRL_RESET;
    end
    // a wrap in the clearing cycle is not lost
    if (cnt_if.reached_zero) begin
      next_wrap_flag = 1'b1;
    end
  end

  // ==========================================================
  // read data, exception request and acknowledge
  always_comb begin
    next_rdata = WORD_ZERO;
    if (i_reg_read && !i_reg_write) begin
      unique case (i_reg_addr)
        OFS_TICK_CONTROL_STATUS: begin
          next_rdata[BIT_COUNTER_ENABLE]        = counter_enable;
          next_rdata[BIT_WRAP_INTERRUPT_ENABLE] = wrap_interrupt_enable;
          next_rdata[BIT_CLOCK_SOURCE_SELECT]   = source_effective;
          next_rdata[BIT_WRAP_FLAG]             = wrap_flag;
        end
        OFS_TICK_RELOAD_VALUE: begin
          next_rdata[CNT_W-1:0] = reload_value;
        end
        OFS_TICK_CURRENT_VALUE: begin
          next_rdata[CNT_W-1:0] = cnt_if.value;
        end
        OFS_TICK_CALIBRATION: begin
          next_rdata[BIT_NO_REFERENCE_CLOCK] = NO_REFERENCE_CLOCK;
          next_rdata[BIT_CALIB_SKEW]         = CALIB_SKEW;
          next_rdata[CNT_W-1:0]              = TEN_MILLISECOND_COUNT;
        end
        default: begin
          next_rdata = WORD_ZERO;
        end
      endcase
    end
    next_ack       = i_reg_read | i_reg_write;
    next_exception = cnt_if.reached_zero & wrap_interrupt_enable;
  end

  // ==========================================================
  // registers; reload only resets for a defined simulation start
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      counter_enable           <= CTRL_RESET;
      wrap_interrupt_enable    <= CTRL_RESET;
      clock_source_select      <= CTRL_RESET;
      wrap_flag                <= CTRL_RESET;
      reload_value             <= COUNT_ZERO;
      o_reg_rdata              <= WORD_ZERO;
      o_reg_ack                <= CTRL_RESET;
      o_tick_exception_request <= CTRL_RESET;
    end else begin
      counter_enable           <= next_counter_enable;
      wrap_interrupt_enable    <= next_wrap_interrupt_enable;
      clock_source_select      <= next_clock_source_select;
      wrap_flag                <= next_wrap_flag;
      reload_value             <= next_reload_value;
      o_reg_rdata              <= next_rdata;
      o_reg_ack                <= next_ack;
      o_tick_exception_request <= next_exception;
    end
  end

  // ==========================================================
  // assertions
  sequence s_hit_zero;
    cnt_if.reached_zero;
  endsequence

  sequence s_tick_nonzero;
    cnt_if.tick && !cnt_if.clear && (cnt_if.value != COUNT_ZERO);
  endsequence

  property p_flag_after_zero;
    @(posedge i_clk_sys) disable iff (i_rst)
      s_hit_zero |=> wrap_flag;
  endproperty
  a_flag_after_zero: assert property (p_flag_after_zero)
    else $error("wrap flag not set after reaching zero");

  property p_read_clears_flag;
    @(posedge i_clk_sys) disable iff (i_rst)
      rd_csr && !cnt_if.reached_zero |=> !wrap_flag ##0 o_reg_ack;
  endproperty
  a_read_clears_flag: assert property (p_read_clears_flag)
    else $error("control read did not clear wrap flag");

  property p_source_reads;
    @(posedge i_clk_sys) disable iff (i_rst)
      rd_csr |=> o_reg_rdata[BIT_CLOCK_SOURCE_SELECT] ==
                 ($past(clock_source_select) | NO_REFERENCE_CLOCK);
  endproperty
  a_source_reads: assert property (p_source_reads)
    else $error("clock source bit read back wrong");

  property p_ref_gates_tick;
    @(posedge i_clk_sys) disable iff (i_rst)
      !source_effective && !ref_pulse |-> !cnt_if.tick;
  endproperty
  a_ref_gates_tick: assert property (p_ref_gates_tick)
    else $error("counted without reference pulse");

  property p_request_enabled;
    @(posedge i_clk_sys) disable iff (i_rst)
      s_hit_zero ##0 wrap_interrupt_enable |=> o_tick_exception_request;
  endproperty
  a_request_enabled: assert property (p_request_enabled)
    else $error("exception request missing");

  property p_request_masked;
    @(posedge i_clk_sys) disable iff (i_rst)
      !cnt_if.reached_zero || !wrap_interrupt_enable |=> !o_tick_exception_request;
  endproperty
  a_request_masked: assert property (p_request_masked)
    else $error("unexpected exception request");

  property p_hold_disabled;
    @(posedge i_clk_sys) disable iff (i_rst)
      !counter_enable && !wr_cvr |=> $stable(cnt_if.value);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled)
    else $error("counter moved while disabled");

  property p_reload_at_zero;
    @(posedge i_clk_sys) disable iff (i_rst)
      cnt_if.tick && !cnt_if.clear && cnt_if.value == COUNT_ZERO
        |=> cnt_if.value == $past(reload_value);
  endproperty
  a_reload_at_zero: assert property (p_reload_at_zero)
    else $error("reload not taken at zero");

  property p_zero_event_step;
    @(posedge i_clk_sys) disable iff (i_rst)
      s_hit_zero |-> cnt_if.value == COUNT_ZERO && $past(cnt_if.value) == COUNT_ONE;
  endproperty
  a_zero_event_step: assert property (p_zero_event_step)
    else $error("zero event without one-to-zero step");

  property p_decrement;
    @(posedge i_clk_sys) disable iff (i_rst)
      s_tick_nonzero |=> cnt_if.value == $past(cnt_if.value) - COUNT_ONE;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("counter did not step down by one");

  property p_write_clears;
    @(posedge i_clk_sys) disable iff (i_rst)
      wr_cvr |=> cnt_if.value == COUNT_ZERO && wrap_flag == $past(cnt_if.reached_zero);
  endproperty
  a_write_clears: assert property (p_write_clears)
    else $error("current value write did not clear");

  property p_calibration_reads;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_reg_read && !i_reg_write && i_reg_addr == OFS_TICK_CALIBRATION
        |=> o_reg_rdata[BIT_NO_REFERENCE_CLOCK] == NO_REFERENCE_CLOCK
            && o_reg_rdata[BIT_CALIB_SKEW] == CALIB_SKEW
            && o_reg_rdata[CNT_W-1:0] == TEN_MILLISECOND_COUNT;
  endproperty
  a_calibration_reads: assert property (p_calibration_reads)
    else $error("calibration read back wrong");

  sequence s_any_access;
    i_reg_read || i_reg_write;
  endsequence

  sequence s_read_unmapped;
    i_reg_read && !i_reg_write
      && i_reg_addr != OFS_TICK_CONTROL_STATUS
      && i_reg_addr != OFS_TICK_RELOAD_VALUE
      && i_reg_addr != OFS_TICK_CURRENT_VALUE
      && i_reg_addr != OFS_TICK_CALIBRATION;
  endsequence

  sequence s_pin_rise;
    !i_reference_tick ##1 i_reference_tick;
  endsequence

  // every strobe cycle is answered on the next edge, unmapped ones too
  property p_ack_follows;
    @(posedge i_clk_sys) disable iff (i_rst)
      s_any_access |=> o_reg_ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("access not acknowledged");

  property p_no_stray_ack;
    @(posedge i_clk_sys) disable iff (i_rst)
      !i_reg_read && !i_reg_write |=> !o_reg_ack && o_reg_rdata == WORD_ZERO;
  endproperty
  a_no_stray_ack: assert property (p_no_stray_ack)
    else $error("acknowledge or data without an access");

  property p_unmapped_zero;
    @(posedge i_clk_sys) disable iff (i_rst)
      s_read_unmapped |=> o_reg_rdata == WORD_ZERO;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped offset returned data");

  // a part without a reference may never report the external source
  property p_source_forced;
    @(posedge i_clk_sys) disable iff (i_rst)
      rd_csr && NO_REFERENCE_CLOCK |=> o_reg_rdata[BIT_CLOCK_SOURCE_SELECT];
  endproperty
  a_source_forced: assert property (p_source_forced)
    else $error("clock source bit cleared without reference");

  // a wrap in the same cycle keeps the flag, so only the quiet case is checked
  property p_cvr_clears_flag;
    @(posedge i_clk_sys) disable iff (i_rst)
      wr_cvr && !cnt_if.reached_zero |=> !wrap_flag;
  endproperty
  a_cvr_clears_flag: assert property (p_cvr_clears_flag)
    else $error("current value write left wrap flag set");

  // two synchroniser stages and the edge register: three edges of latency
  property p_ref_pulse_delay;
    @(posedge i_clk_sys) disable iff (i_rst)
      s_pin_rise |-> ##3 ref_pulse;
  endproperty
  a_ref_pulse_delay: assert property (p_ref_pulse_delay)
    else $error("reference rise gave no count enable");

  property p_ref_pulse_single;
    @(posedge i_clk_sys) disable iff (i_rst)
      ref_pulse |=> !ref_pulse;
  endproperty
  a_ref_pulse_single: assert property (p_ref_pulse_single)
    else $error("reference count enable longer than one cycle");

endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  import system_tick_pkg::*;
  // ==========================================================
  // settings
  localparam logic [CNT_W-1:0]  TEN_COUNT    = 24'h0012AB; // arbitrary calibration count
  localparam logic [ADDR_W-1:0] OFS_UNMAPPED = 16'hE020;
  localparam int                TIME_LIMIT   = 20000;

  logic              clk_sys;
  logic              rst;
  logic              reg_read;
  logic              reg_write;
  logic              ref_tick;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic [DATA_W-1:0] rdata_b;
  logic              reg_ack;
  logic              exc_req;
  logic [DATA_W-1:0] exp_q[$];
  logic [CNT_W-1:0]  rel;
  int                err_total;
  int                checked;
  int                cycles;
  int                n;

  // ==========================================================
  // units under test; the second lacks a reference clock
  system_tick_timer #(
    .NO_REFERENCE_CLOCK   (1'b0),
    .CALIB_SKEW           (1'b1),
    .TEN_MILLISECOND_COUNT(TEN_COUNT)
  ) system_tick_timer_inst (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_reg_read(reg_read), .i_reg_write(reg_write),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .o_reg_ack(reg_ack), .i_reference_tick(ref_tick), .o_tick_exception_request(exc_req)
  );
  system_tick_timer #(
    .NO_REFERENCE_CLOCK   (1'b1),
    .CALIB_SKEW           (1'b0),
    .TEN_MILLISECOND_COUNT(24'h000000)
  ) system_tick_timer_no_reference_clock_inst (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_reg_read(reg_read), .i_reg_write(reg_write),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata_b),
    .o_reg_ack(), .i_reference_tick(ref_tick), .o_tick_exception_request()
  );

  always #2 clk_sys = ~clk_sys;

  // ==========================================================
  // checking
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // every ack takes the oldest note; writes answer with zero data
  always @(negedge clk_sys) begin
    if (reg_ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk({31'h00000000, reg_ack}, WORD_ZERO);
      end else begin
        chk(reg_rdata, exp_q.pop_front());
      end
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == TIME_LIMIT) begin
      err_total++;
      conclude();
    end
  end

  // ==========================================================
  // drivers; strobes stay up between back-to-back accesses
  task automatic acc(input logic r, input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] exp);
    @(posedge clk_sys);
    reg_read  <= r;
    reg_write <= w;
    reg_addr  <= a;
    reg_wdata <= d;
    exp_q.push_back(exp);
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    acc(1'b1, 1'b0, a, $urandom, exp);
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    acc(1'b0, 1'b1, a, d, WORD_ZERO);
  endtask

  task automatic idle(input int k);
    @(posedge clk_sys);
    reg_read  <= 1'b0;
    reg_write <= 1'b0;
    repeat (k - 1) @(posedge clk_sys);
  endtask

  task automatic ref_pulse(input int k);
    repeat (k) begin
      @(posedge clk_sys);
      ref_tick <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ref_tick <= 1'b0;
      repeat (6) @(posedge clk_sys);
    end
  endtask

  // counts cycles up to the next exception pulse, at most lim
  task automatic wait_exc(input int lim, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk_sys);
      cnt++;
    end while (exc_req !== 1'b1 && cnt < lim);
  endtask

  // ==========================================================
  // tests
  initial begin
    clk_sys = 1'b0; rst = 1'b1; reg_read = 1'b0; reg_write = 1'b0; ref_tick = 1'b0;
    reg_addr = '0; reg_wdata = '0; err_total = 0; checked = 0; cycles = 0;
    void'($urandom(19));
    rel = CNT_W'(3 + $urandom % 18);
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;

    rd_reg(OFS_TICK_CONTROL_STATUS, WORD_ZERO);
    rd_reg(OFS_TICK_CALIBRATION, 32'h40000000 | TEN_COUNT);
    wr_reg(OFS_TICK_CALIBRATION, 32'hFFFFFFFF);
    rd_reg(OFS_TICK_CALIBRATION, 32'h40000000 | TEN_COUNT);
    wr_reg(OFS_UNMAPPED, $urandom);
    rd_reg(OFS_UNMAPPED, WORD_ZERO);
    wr_reg(OFS_TICK_CONTROL_STATUS, 32'hFFFFFFFC);
    rd_reg(OFS_TICK_CONTROL_STATUS, 32'h00000004);
    wr_reg(OFS_TICK_CONTROL_STATUS, WORD_ZERO);
    rd_reg(OFS_TICK_CONTROL_STATUS, WORD_ZERO);
    idle(1);
    @(negedge clk_sys);
    chk(rdata_b, 32'h00000004);
    rd_reg(OFS_TICK_CALIBRATION, 32'h40000000 | TEN_COUNT);
    idle(1);
    @(negedge clk_sys);
    chk(rdata_b, 32'h80000000);
    wr_reg(OFS_TICK_RELOAD_VALUE, 32'hFFFFFFFF);
    rd_reg(OFS_TICK_RELOAD_VALUE, 32'h00FFFFFF);
    idle(1);
    $display("test registers done");

    wr_reg(OFS_TICK_RELOAD_VALUE, {8'h00, rel});
    wr_reg(OFS_TICK_CONTROL_STATUS, 32'h00000004);
    wr_reg(OFS_TICK_CURRENT_VALUE, $urandom);
    rd_reg(OFS_TICK_CURRENT_VALUE, WORD_ZERO);
    idle(10);
    rd_reg(OFS_TICK_CURRENT_VALUE, WORD_ZERO);
    wr_reg(OFS_TICK_CONTROL_STATUS, 32'h00000001);
    idle(1);
    ref_pulse(2);
    rd_reg(OFS_TICK_CURRENT_VALUE, {8'h00, rel - COUNT_ONE});
    idle(1);
    ref_pulse(int'(rel) - 1);
    rd_reg(OFS_TICK_CURRENT_VALUE, WORD_ZERO);
    rd_reg(OFS_TICK_CONTROL_STATUS, 32'h00010001);
    rd_reg(OFS_TICK_CONTROL_STATUS, 32'h00000001);
    idle(1);
    $display("test reference count done");

    wr_reg(OFS_TICK_CURRENT_VALUE, WORD_ZERO);
    wr_reg(OFS_TICK_CONTROL_STATUS, 32'h00000007);
    idle(1);
    wait_exc(100, n);
    wait_exc(100, n);
    chk(n, int'(rel) + 1);
    wr_reg(OFS_TICK_CONTROL_STATUS, 32'h00000006);
    idle(2);
    rd_reg(OFS_TICK_CONTROL_STATUS, 32'h00010006);
    rd_reg(OFS_TICK_CONTROL_STATUS, 32'h00000006);
    wr_reg(OFS_TICK_CONTROL_STATUS, 32'h00000005);
    idle(1);
    wait_exc(3 * (int'(rel) + 1), n);
    chk(n, 3 * (int'(rel) + 1));
    wr_reg(OFS_TICK_CONTROL_STATUS, 32'h00000004);
    idle(2);
    wr_reg(OFS_TICK_CURRENT_VALUE, $urandom);
    rd_reg(OFS_TICK_CONTROL_STATUS, 32'h00000004);
    idle(1);
    $display("test processor clock done");

    wr_reg(OFS_TICK_RELOAD_VALUE, WORD_ZERO);
    wr_reg(OFS_TICK_CURRENT_VALUE, WORD_ZERO);
    wr_reg(OFS_TICK_CONTROL_STATUS, 32'h00000007);
    idle(1);
    wait_exc(40, n);
    chk(n, 40);
    rd_reg(OFS_TICK_CONTROL_STATUS, 32'h00000007);
    rd_reg(OFS_TICK_CURRENT_VALUE, WORD_ZERO);
    idle(3);
    chk(exp_q.size(), 0);
    $display("test zero reload done");
    conclude();
  end
endmodule

/* File: tick_count_if.sv */
`timescale 1ns/1ps
// ==========================================================
// link between register file and counter core
interface tick_count_if;
  import system_tick_pkg::*;
  logic             tick;
  logic             clear;
  logic [CNT_W-1:0] reload;
  logic [CNT_W-1:0] value;
  logic             reached_zero;

  modport core (input tick, input clear, input reload, output value, output reached_zero);
  modport ctrl (output tick, output clear, output reload, input value, input reached_zero);
endinterface

/* File: tick_down_counter.sv */
`timescale 1ns/1ps
// ==========================================================
// 24-bit down counter with reload at zero
module tick_down_counter (
  // clock and reset
  input  wire logic  i_clk_sys,
  input  wire logic  i_rst,
  // counter link
  tick_count_if.core cnt
);
  import system_tick_pkg::*;

  logic [CNT_W-1:0] next_value;
  logic             next_reached_zero;

  always_comb begin
    next_value        = cnt.value;
    next_reached_zero = CTRL_RESET;
    if (cnt.clear) begin
      next_value = COUNT_ZERO;
    end else if (cnt.tick) begin
      if (cnt.value == COUNT_ZERO) begin
        next_value = cnt.reload;
      end else begin
        next_value        = cnt.value - COUNT_ONE;
        next_reached_zero = (cnt.value == COUNT_ONE);
      end
    end
  end

  // reset to zero only for determinism, software still programs both
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt.value        <= COUNT_ZERO;
      cnt.reached_zero <= CTRL_RESET;
    end else begin
      cnt.value        <= next_value;
      cnt.reached_zero <= next_reached_zero;
    end
  end
endmodule

/* File: tick_ref_sync.sv */
`timescale 1ns/1ps
// ==========================================================
// reference tick synchroniser and rising edge pulse
module tick_ref_sync (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // reference tick from the watchdog
  input  wire logic i_reference_tick,
  // one cycle count enable
  output logic      o_ref_pulse
);
  import system_tick_pkg::*;

  logic sync_first, sync_second, sync_prev;
  logic next_first, next_second, next_prev, next_pulse;

  // first stage feeds only the second stage
  always_comb begin
    next_first  = i_reference_tick;
    next_second = sync_first;
    next_prev   = sync_second;
    next_pulse  = sync_second & ~sync_prev;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync_first  <= CTRL_RESET;
      sync_second <= CTRL_RESET;
      sync_prev   <= CTRL_RESET;
      o_ref_pulse <= CTRL_RESET;
    end else begin
      sync_first  <= next_first;
      sync_second <= next_second;
      sync_prev   <= next_prev;
      o_ref_pulse <= next_pulse;
    end
  end
endmodule
